//--- design/drive_current_map.svh
// register offsets, reset code and scale constants for the drive-current bank
`ifndef DRIVE_CURRENT_MAP_SVH
`define DRIVE_CURRENT_MAP_SVH
`define SOURCE1_DRIVE_CURRENT_OFS 8'h26
`define SOURCE2_DRIVE_CURRENT_OFS 8'h27
`define SOURCE3_DRIVE_CURRENT_OFS 8'h28
`define SOURCE4_DRIVE_CURRENT_OFS 8'h29
`define SOURCE5_DRIVE_CURRENT_OFS 8'h2a
`define SOURCE6_DRIVE_CURRENT_OFS 8'h2b
`define DRIVE_CURRENT_RESET 8'haf
`define DRIVE_CURRENT_ZERO 8'h00
`define DRIVE_CURRENT_FULL 8'hff
`define DRIVE_CURRENT_STEP_UA 100
`define DRIVE_CURRENT_CODE_W 8
`endif

//--- design/drive_current_pkg.sv
// types shared by the drive-current register bank
package drive_current_pkg;
   // one register access from the two-wire control interface
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef logic [7:0] level_code_t;
endpackage

//--- design/level_code_cell.sv
// one 8-bit drive-current code register with its own write strobe
`timescale 1ns/1ps
`include "drive_current_map.svh"
module level_code_cell (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire drive_current_pkg::level_code_t wdata,
   output drive_current_pkg::level_code_t code_q
);
   import drive_current_pkg::*;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         code_q <= `DRIVE_CURRENT_RESET;
      end else if (clk_en && wr_en) begin
         code_q <= wdata;
      end
   end
endmodule

//--- design/led_drive_current_regs.sv
// bank of six drive-current code registers for the LED current sources
`timescale 1ns/1ps
`include "drive_current_map.svh"
module led_drive_current_regs #(
   parameter int NUM_SOURCES = 6
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire drive_current_pkg::reg_req_t req,
   output drive_current_pkg::level_code_t rdata_q,
   output logic rd_hit_q,
   output drive_current_pkg::level_code_t source1_level_code,
   output drive_current_pkg::level_code_t source2_level_code,
   output drive_current_pkg::level_code_t source3_level_code,
   output drive_current_pkg::level_code_t source4_level_code,
   output drive_current_pkg::level_code_t source5_level_code,
   output drive_current_pkg::level_code_t source6_level_code
);
   import drive_current_pkg::*;

   level_code_t codes [NUM_SOURCES];
   logic [47:0] codes_flat;
   logic [NUM_SOURCES-1:0] sel;
   logic hit;
   level_code_t rsel;
   level_code_t rdata_d;

   // one-hot select of the addressed source, none outside the bank
   function automatic logic [NUM_SOURCES-1:0] decode(input logic [7:0] a);
      logic [7:0] idx;
      idx = a - `SOURCE1_DRIVE_CURRENT_OFS;
      decode = '0;
      if (a >= `SOURCE1_DRIVE_CURRENT_OFS && idx < 8'(NUM_SOURCES)) begin
         decode[idx[2:0]] = 1'b1;
      end
   endfunction

   assign sel = decode(req.addr);
   assign hit = |sel;

   genvar g;
   generate
      for (g = 0; g < NUM_SOURCES; g++) begin : g_src
         level_code_cell u_cell (
            .mclk(mclk),
            .rst_b(rst_b),
            .clk_en(clk_en),
            .wr_en(req.wr & sel[g]),
            .wdata(req.wdata),
            .code_q(codes[g])
         );
      end
   endgenerate

   // read mux, unmapped addresses read zero
   always_comb begin
      rsel = `DRIVE_CURRENT_ZERO;
      for (int i = 0; i < NUM_SOURCES; i++) begin
         if (sel[i]) begin
            rsel = codes[i];
         end
      end
   end
   assign rdata_d = req.rd ? rsel : rdata_q;

   // read data registered so the interface sees a stable byte
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= `DRIVE_CURRENT_ZERO;
         rd_hit_q <= 1'b0;
      end else if (clk_en) begin
         rdata_q <= rdata_d;
         rd_hit_q <= req.rd & hit;
      end
   end

   // code goes straight to the analogue source, linear by construction
   assign source1_level_code = codes[0];
   assign source2_level_code = codes[1];
   assign source3_level_code = codes[2];
   assign source4_level_code = codes[3];
   assign source5_level_code = codes[4];
   assign source6_level_code = codes[5];

   // all six outputs side by side, so one check can watch the whole bank at once
   assign codes_flat = {source6_level_code, source5_level_code, source4_level_code,
      source3_level_code, source2_level_code, source1_level_code};

   // checks on the bank; all but the reset ones stay quiet while rst_b is low,
   // since the flops change asynchronously then and a sampled past value would mislead

   a_reset_code: assert property (@(posedge mclk) $rose(rst_b)
      |-> codes[0] == `DRIVE_CURRENT_RESET)
      else $error("source code not at reset value");
   a_reset_bank: assert property (@(posedge mclk) $rose(rst_b)
      |-> codes_flat == {6{`DRIVE_CURRENT_RESET}})
      else $error("bank not at reset code after reset");

   a_isolated_write: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && !sel[0]) |=> $stable(codes[0]))
      else $error("unaddressed source code changed");
   a_isolated_src2: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && !sel[1]) |=> $stable(codes[1]))
      else $error("unaddressed second source code changed");
   a_isolated_src3: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && !sel[2]) |=> $stable(codes[2]))
      else $error("unaddressed third source code changed");
   a_isolated_src4: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && !sel[3]) |=> $stable(codes[3]))
      else $error("unaddressed fourth source code changed");
   a_isolated_src5: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && !sel[4]) |=> $stable(codes[4]))
      else $error("unaddressed fifth source code changed");
   a_isolated_src6: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && !sel[5]) |=> $stable(codes[5]))
      else $error("unaddressed sixth source code changed");
   a_unmapped_write: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && !hit) |=> $stable(codes_flat))
      else $error("write outside the bank changed a code");

   a_first_offset: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && req.addr == `SOURCE1_DRIVE_CURRENT_OFS)
      |=> codes[0] == $past(req.wdata))
      else $error("write to first offset lost");
   a_second_offset: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && req.addr == `SOURCE2_DRIVE_CURRENT_OFS)
      |=> codes[1] == $past(req.wdata))
      else $error("write to second offset lost");
   a_third_offset: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && req.addr == `SOURCE3_DRIVE_CURRENT_OFS)
      |=> codes[2] == $past(req.wdata))
      else $error("write to third offset lost");
   a_fourth_offset: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && req.addr == `SOURCE4_DRIVE_CURRENT_OFS)
      |=> codes[3] == $past(req.wdata))
      else $error("write to fourth offset lost");
   a_fifth_offset: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && req.addr == `SOURCE5_DRIVE_CURRENT_OFS)
      |=> codes[4] == $past(req.wdata))
      else $error("write to fifth offset lost");
   a_last_offset: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && req.addr == `SOURCE6_DRIVE_CURRENT_OFS)
      |=> codes[5] == $past(req.wdata))
      else $error("write to last offset lost");

   a_decode_range: assert property (@(posedge mclk) disable iff (!rst_b)
      hit == (req.addr >= `SOURCE1_DRIVE_CURRENT_OFS &&
      req.addr <= `SOURCE6_DRIVE_CURRENT_OFS))
      else $error("address decode range wrong");
   a_one_select: assert property (@(posedge mclk) disable iff (!rst_b) $onehot0(sel))
      else $error("more than one source selected");

   a_read_first: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.rd && sel[0]) |=> rdata_q == $past(codes[0]))
      else $error("first source read data mismatch");
   a_read_second: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.rd && sel[1]) |=> rdata_q == $past(codes[1]))
      else $error("second source read data mismatch");
   a_read_back: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.rd && sel[2]) |=> rdata_q == $past(codes[2]))
      else $error("read data mismatch");
   a_read_fourth: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.rd && sel[3]) |=> rdata_q == $past(codes[3]))
      else $error("fourth source read data mismatch");
   a_read_fifth: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.rd && sel[4]) |=> rdata_q == $past(codes[4]))
      else $error("fifth source read data mismatch");
   a_read_last: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.rd && sel[5]) |=> rdata_q == $past(codes[5]))
      else $error("sixth source read data mismatch");
   a_unmapped_read: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.rd && !hit) |=> (rdata_q == `DRIVE_CURRENT_ZERO && !rd_hit_q))
      else $error("unmapped read not answered with zero");
   a_read_hit: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.rd && hit) |=> rd_hit_q)
      else $error("mapped read not acknowledged");
   a_hit_single: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && !req.rd) |=> !rd_hit_q)
      else $error("read acknowledge stayed high");
   // read data holds, so a slow interface may take it late
   a_rdata_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      !(clk_en && req.rd) |=> $stable(rdata_q))
      else $error("read data changed without a read");

   a_frozen_bank: assert property (@(posedge mclk) disable iff (!rst_b)
      !clk_en |=> $stable(codes_flat))
      else $error("code changed while clock enable low");
   a_full_scale: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && sel[5] && req.wdata == `DRIVE_CURRENT_FULL) |=> codes[5] == 8'hff)
      else $error("full scale code not stored");
   a_zero_code: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && req.wr && sel[0] && req.wdata == `DRIVE_CURRENT_ZERO) |=> codes[0] == 8'h00)
      else $error("zero code not stored");
endmodule

//--- test/tb.sv
// self-checking bench for the drive-current register bank
`timescale 1ns/1ps
`include "drive_current_map.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
$display("ERROR %s expected %h seen %h", n, e, s); end end
module tb;
   import drive_current_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   reg_req_t req = '0;
   level_code_t rdata_q;
   logic rd_hit_q;
   level_code_t code[6];
   level_code_t exp_code[6];
   int mismatches = 0;
   int compares = 0;
   always #5 mclk = ~mclk;
   led_drive_current_regs led_drive_current_regs_i (.mclk(mclk), .rst_b(rst_b),
      .clk_en(clk_en), .req(req), .rdata_q(rdata_q), .rd_hit_q(rd_hit_q),
      .source1_level_code(code[0]), .source2_level_code(code[1]),
      .source3_level_code(code[2]), .source4_level_code(code[3]),
      .source5_level_code(code[4]), .source6_level_code(code[5]));
   // one request held for a single edge, checks land just after that edge
   task automatic access(input logic w, input logic [7:0] a, input level_code_t d);
      @(posedge mclk) req <= '{w, !w, a, d};
      @(posedge mclk) req <= '0;
      #1;
   endtask
   task automatic all_codes();
      for (int i = 0; i < 6; i++) `CHK("source code", exp_code[i], code[i])
   endtask
   task automatic rd(input logic [7:0] a, input level_code_t e, input logic hit);
      access(1'b0, a, 8'h00);
      `CHK("read data", e, rdata_q)
      `CHK("read hit", hit, rd_hit_q)
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // main sequence: reset codes, per-source writes, boundary codes, unmapped places
   initial begin
      foreach (exp_code[i]) exp_code[i] = `DRIVE_CURRENT_RESET;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      #1 all_codes();
      for (int i = 0; i < 6; i++) rd(8'(8'h26 + i), `DRIVE_CURRENT_RESET, 1'b1);
      // codes 00, 33, 66, 99, cc, ff: zero and full scale both covered
      for (int i = 0; i < 6; i++) begin
         access(1'b1, 8'(8'h26 + i), level_code_t'(8'h33 * i));
         exp_code[i] = level_code_t'(8'h33 * i);
         all_codes();
      end
      for (int i = 0; i < 6; i++) rd(8'(8'h26 + i), exp_code[i], 1'b1);
      access(1'b1, 8'h25, 8'h5a);
      access(1'b1, 8'h2c, 8'h5a);
      all_codes();
      rd(8'h25, 8'h00, 1'b0);
      rd(8'h2c, 8'h00, 1'b0);
      // a frozen clock enable must not let a write through
      @(posedge mclk) clk_en <= 1'b0;
      access(1'b1, 8'h26, 8'h77);
      all_codes();
      @(posedge mclk) clk_en <= 1'b1;
      access(1'b1, 8'h2b, `DRIVE_CURRENT_ZERO);
      exp_code[5] = `DRIVE_CURRENT_ZERO;
      rd(8'h2b, `DRIVE_CURRENT_ZERO, 1'b1);
      all_codes();
      // mid-run reset must put every written code back to the reset value
      @(posedge mclk) rst_b <= 1'b0;
      @(posedge mclk) rst_b <= 1'b1;
      foreach (exp_code[i]) exp_code[i] = `DRIVE_CURRENT_RESET;
      #1 all_codes();
      rd(8'h2b, `DRIVE_CURRENT_RESET, 1'b1);
      give_verdict();
   end
   // watchdog: the sequence needs well under 20 us
   initial begin
      #20000;
      mismatches++;
      give_verdict();
   end
endmodule
